// ==== core/efsr_pkg.sv ====
// Shared constants for the error flag status register block
package efsr_pkg;
    // Register port
    localparam logic [7:0]  EFSR_ERR_ADDR     = 8'h06;  // Offset of the error flag register
    localparam logic [7:0]  EFSR_LAST_ADDR    = 8'h3f;  // Highest valid register offset
    localparam int          EFSR_REG_W        = 16;     // Register width
    localparam int          EFSR_NFLAGS       = 9;      // Flags held here, bits 8..0
    localparam logic [15:0] EFSR_ERR_RESET    = 16'h0000; // Reset value of all flags
    // Field positions
    localparam int          EFSR_B_REF_DET    = 8;      // Reference detection fault
    localparam int          EFSR_B_CONV       = 7;      // Converter fault
    localparam int          EFSR_B_IGNORE     = 6;      // Ignored serial access
    localparam int          EFSR_B_CLK_CNT    = 5;      // Clock count fault
    localparam int          EFSR_B_RD_ADDR    = 4;      // Invalid read address
    localparam int          EFSR_B_WR_ADDR    = 3;      // Invalid write address
    localparam int          EFSR_B_SER_CRC    = 2;      // Serial CRC mismatch
    localparam int          EFSR_B_MAP_CRC    = 1;      // Register map CRC fault
    localparam int          EFSR_B_ROM_CRC    = 0;      // ROM CRC fault
    // CRC scanning
    localparam int          EFSR_CRC_W        = 8;      // CRC width
    localparam logic [7:0]  EFSR_CRC_POLY     = 8'h07;  // CRC polynomial
    localparam logic [7:0]  EFSR_CRC_INIT     = 8'hff;  // CRC start value
    localparam int          EFSR_ROM_AW       = 8;      // ROM address width
    localparam logic [7:0]  EFSR_ROM_LAST     = 8'hff;  // Last ROM word
    localparam int          EFSR_MAP_AW       = 6;      // Register map address width
    localparam logic [5:0]  EFSR_MAP_LAST     = 6'h3f;  // Last map word
    // Timing
    localparam int          EFSR_CLK_MHZ      = 50;     // System clock rate
    localparam int          EFSR_MAP_PERIOD_US = 100;   // Register map check interval
    localparam int          EFSR_MAP_PERIOD_CYC = EFSR_MAP_PERIOD_US * EFSR_CLK_MHZ;
endpackage : efsr_pkg

// ==== core/efsr_crc_scan.sv ====
// Walks a word memory and accumulates a CRC over its contents
`timescale 1ns/100ps
module efsr_crc_scan
    import efsr_pkg::*;
#(
    parameter int              AW   = 8,
    parameter logic [AW-1:0]   LAST = '1
) (
    input  wire logic                  clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  start_i,   // Begin a scan
    output logic [AW-1:0]              addr_o,    // Word being read
    input  wire logic [EFSR_REG_W-1:0] data_i,    // Word at addr_o, same cycle
    output logic                       busy_o,    // Scan in progress
    output logic                       done_o,    // One-cycle end of scan
    output logic [EFSR_CRC_W-1:0]      crc_o      // Result, valid with done_o
);
    logic [AW-1:0]         addr_q;   // Scan address
    logic                  busy_q;   // Scan active
    logic                  done_q;   // End pulse
    logic [EFSR_CRC_W-1:0] crc_q;    // Running CRC

    // Serial CRC step over one word, most significant bit first
    function automatic logic [EFSR_CRC_W-1:0] crc_step(input logic [EFSR_CRC_W-1:0] c,
                                                       input logic [EFSR_REG_W-1:0] d);
        logic [EFSR_CRC_W-1:0] r;
        r = c;
        for (int i = EFSR_REG_W - 1; i >= 0; i--) begin
            if (r[EFSR_CRC_W-1] ^ d[i]) begin
                r = {r[EFSR_CRC_W-2:0], 1'b0} ^ EFSR_CRC_POLY;
            end else begin
                r = {r[EFSR_CRC_W-2:0], 1'b0};
            end
        end
        return r;
    endfunction : crc_step

    // Address walk and accumulation
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            crc_q  <= EFSR_CRC_INIT;
        end else begin
            done_q <= 1'b0;
            if (!busy_q) begin
                if (start_i) begin            // Fresh scan
                    busy_q <= 1'b1;
                    addr_q <= '0;
                    crc_q  <= EFSR_CRC_INIT;
                end
            end else begin
                crc_q <= crc_step(crc_q, data_i);
                if (addr_q == LAST) begin     // Last word folded in
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    addr_q <= addr_q + 1'b1;
                end
            end
        end
    end

    assign addr_o = addr_q;
    assign busy_o = busy_q;
    assign done_o = done_q;
    assign crc_o  = crc_q;
endmodule : efsr_crc_scan

// ==== core/efsr_frame_mon.sv ====
// Watches serial chip-select frames for clock count and ignored access
`timescale 1ns/100ps
module efsr_frame_mon
    import efsr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic sclk_i,        // Serial clock pin
    input  wire logic cs_n_i,        // Chip select pin, active low
    input  wire logic ignore_i,      // Accesses are disregarded now
    output logic      cnt_fault_o,   // Frame ended off a byte boundary
    output logic      ignore_o       // Frame started while disregarded
);
    logic [2:0] sclk_s_q;   // Serial clock synchroniser
    logic [2:0] cs_s_q;     // Chip select synchroniser
    logic       sclk_lv_q;  // Agreed serial clock level
    logic       cs_lv_q;    // Agreed chip select level
    logic [2:0] edge_cnt_q; // Rising edges modulo eight
    logic       fault_q;    // Count fault pulse
    logic       ign_q;      // Ignore pulse

    // Three-stage capture of both pins
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_s_q <= 3'h0;
            cs_s_q   <= 3'h7;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], sclk_i};
            cs_s_q   <= {cs_s_q[1:0], cs_n_i};
        end
    end

    // Levels move only when stages two and three agree
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_lv_q <= 1'b0;
            cs_lv_q   <= 1'b1;
        end else begin
            if (sclk_s_q[1] == sclk_s_q[2]) begin
                sclk_lv_q <= sclk_s_q[2];
            end
            if (cs_s_q[1] == cs_s_q[2]) begin
                cs_lv_q <= cs_s_q[2];
            end
        end
    end

    // Edge counting and frame-end checks
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            edge_cnt_q <= 3'h0;
            fault_q    <= 1'b0;
            ign_q      <= 1'b0;
        end else begin
            fault_q <= 1'b0;
            ign_q   <= 1'b0;
            if (cs_lv_q && (cs_s_q[1] == cs_s_q[2]) && !cs_s_q[2]) begin  // Frame opens
                edge_cnt_q <= 3'h0;
                ign_q      <= ignore_i;
            end else if (!cs_lv_q && (cs_s_q[1] == cs_s_q[2]) && cs_s_q[2]) begin // Frame closes
                fault_q    <= (edge_cnt_q != 3'h0);
            end else if (!cs_lv_q && !sclk_lv_q && (sclk_s_q[1] == sclk_s_q[2]) && sclk_s_q[2]) begin
                edge_cnt_q <= edge_cnt_q + 3'h1;                         // Rising edge in frame
            end
        end
    end

    assign cnt_fault_o = fault_q;
    assign ignore_o    = ign_q;
endmodule : efsr_frame_mon

// ==== core/efsr_top.sv ====
// Sticky error flag register, bits 8..0, with its fault detectors
// What this block does
// - Reference below threshold sets detection flag
// - Clamped conversion result sets converter flag
// - Calibration range or modulator saturation too
// - Access while disregarded sets ignore flag
// - Frame edges not multiple of eight
// - Read of invalid address sets flag
// - Write of invalid address sets flag
// - Serial CRC mismatch sets bit two
// - Map CRC recomputed periodically while enabled
// - Unexplained map change sets bit one
// - ROM CRC at power-up, bit zero
// - Each flag works only when enabled
// - Flags read one on fault, reset zero
// - Write one clears, zero keeps, reserved zero
`timescale 1ns/100ps
module efsr_top
    import efsr_pkg::*;
#(
    parameter int MAP_PERIOD_CYC = EFSR_MAP_PERIOD_CYC   // Map check interval in cycles
) (
    input  wire logic                    clk_i,
    input  wire logic                    arst_n_i,
    // Register access from the serial port
    input  wire logic [7:0]              reg_addr_i,      // Register offset
    input  wire logic                    reg_wr_i,        // Write strobe
    input  wire logic [EFSR_REG_W-1:0]   reg_wdata_i,     // Write data
    output logic [EFSR_REG_W-1:0]        reg_rdata_o,     // Read data, registered
    // Decoded serial transactions
    input  wire logic                    txn_valid_i,     // Transaction done, one cycle
    input  wire logic                    txn_write_i,     // Transaction was a write
    input  wire logic [7:0]              txn_addr_i,      // Transaction address
    input  wire logic                    txn_crc_bad_i,   // Serial CRC mismatch pulse
    // Serial pins, watched only
    input  wire logic                    sclk_i,          // Serial clock
    input  wire logic                    cs_n_i,          // Chip select, active low
    // Companion enable register bits 8..0
    input  wire logic [EFSR_NFLAGS-1:0]  flag_enable_i,   // Per-flag enables
    // Converter status
    input  wire logic                    ref_below_i,     // external_reference_input under threshold
    input  wire logic                    clamp_pos_i,     // Result at positive full scale
    input  wire logic                    clamp_neg_i,     // Result at negative full scale
    input  wire logic                    cal_range_i,     // Calibration out of range
    input  wire logic                    mod_sat_i,       // Modulator saturated
    // ROM read port
    output logic [EFSR_ROM_AW-1:0]       rom_addr_o,      // ROM word address
    input  wire logic [EFSR_REG_W-1:0]   rom_data_i,      // ROM word
    input  wire logic [EFSR_CRC_W-1:0]   rom_ref_crc_i,   // Expected ROM CRC
    output logic                         rom_busy_o,      // ROM download in progress
    // Register map read port
    output logic [EFSR_MAP_AW-1:0]       map_addr_o,      // Map word address
    input  wire logic [EFSR_REG_W-1:0]   map_data_i,      // Map word
    // Flags
    output logic [EFSR_REG_W-1:0]        error_flags_o    // Current flag register
);
    localparam int PCW = $clog2(MAP_PERIOD_CYC + 1);   // Period counter width

    logic [EFSR_NFLAGS-1:0] flag_q;        // Sticky flags
    logic [EFSR_NFLAGS-1:0] event_d;       // Fault events this cycle
    logic [EFSR_NFLAGS-1:0] clear_d;       // Host clear mask
    logic [EFSR_REG_W-1:0]  rdata_q;       // Read data register
    logic [2:0]             ref_s_q;       // Reference comparator capture
    logic                   ref_lv_q;      // Agreed comparator level
    logic                   clk_fault;     // Clock count fault pulse
    logic                   ign_fault;     // Ignored access pulse
    logic                   rom_start_q;   // Power-up scan launch
    logic                   rom_busy;      // ROM scan running
    logic                   rom_done;      // ROM scan finished
    logic [EFSR_CRC_W-1:0]  rom_crc;       // ROM scan result
    logic                   rom_bad_q;     // ROM mismatch pulse
    logic [PCW-1:0]         per_cnt_q;     // Interval counter
    logic                   map_tick;      // Interval elapsed
    logic                   map_busy;      // Map scan running
    logic                   map_done;      // Map scan finished
    logic [EFSR_CRC_W-1:0]  map_crc;       // Map scan result
    logic [EFSR_CRC_W-1:0]  map_ref_q;     // Reference map CRC
    logic                   map_ref_ok_q;  // Reference is valid
    logic                   map_dirty_q;   // Host wrote since last reference
    logic                   map_bad_q;     // Map mismatch pulse
    logic                   host_wr;       // Valid host write seen

    // Register offset validity
    function automatic logic addr_ok(input logic [7:0] a);
        return (a <= EFSR_LAST_ADDR);
    endfunction : addr_ok

    assign host_wr = txn_valid_i && txn_write_i && addr_ok(txn_addr_i);

    // Comparator capture, three stages, agreement of two and three
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_s_q  <= 3'h0;
            ref_lv_q <= 1'b0;
        end else begin
            ref_s_q <= {ref_s_q[1:0], ref_below_i};
            if (ref_s_q[1] == ref_s_q[2]) begin
                ref_lv_q <= ref_s_q[2];
            end
        end
    end

    // Serial frame monitor
    efsr_frame_mon u_frame_mon (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .sclk_i      (sclk_i),
        .cs_n_i      (cs_n_i),
        .ignore_i    (rom_busy),
        .cnt_fault_o (clk_fault),
        .ignore_o    (ign_fault)
    );

    // Launch the ROM check once after reset release
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rom_start_q <= 1'b1;
        end else begin
            rom_start_q <= 1'b0;
        end
    end

    // ROM scanner
    efsr_crc_scan #(
        .AW   (EFSR_ROM_AW),
        .LAST (EFSR_ROM_LAST)
    ) u_rom_scan (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .start_i  (rom_start_q),
        .addr_o   (rom_addr_o),
        .data_i   (rom_data_i),
        .busy_o   (rom_busy),
        .done_o   (rom_done),
        .crc_o    (rom_crc)
    );

    // ROM result compare
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rom_bad_q <= 1'b0;
        end else begin
            rom_bad_q <= rom_done && (rom_crc != rom_ref_crc_i);
        end
    end

    // Interval timer, runs only while the map check is enabled
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            per_cnt_q <= '0;
        end else if (!flag_enable_i[EFSR_B_MAP_CRC]) begin
            per_cnt_q <= '0;
        end else if (map_tick) begin
            per_cnt_q <= '0;
        end else begin
            per_cnt_q <= per_cnt_q + 1'b1;
        end
    end
    assign map_tick = flag_enable_i[EFSR_B_MAP_CRC] && (per_cnt_q == PCW'(MAP_PERIOD_CYC - 1));

    // Register map scanner
    efsr_crc_scan #(
        .AW   (EFSR_MAP_AW),
        .LAST (EFSR_MAP_LAST)
    ) u_map_scan (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .start_i  (map_tick && !rom_busy),
        .addr_o   (map_addr_o),
        .data_i   (map_data_i),
        .busy_o   (map_busy),
        .done_o   (map_done),
        .crc_o    (map_crc)
    );

    // Map reference upkeep and compare
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            map_ref_q    <= EFSR_CRC_INIT;
            map_ref_ok_q <= 1'b0;
            map_dirty_q  <= 1'b0;
            map_bad_q    <= 1'b0;
        end else begin
            map_bad_q <= 1'b0;
            if (!flag_enable_i[EFSR_B_MAP_CRC]) begin            // Check off, drop reference
                map_ref_ok_q <= 1'b0;
                map_dirty_q  <= 1'b0;
            end else if (map_done) begin
                // Mismatch only counts when no host write explains it
                map_bad_q    <= map_ref_ok_q && !map_dirty_q && !host_wr && (map_crc != map_ref_q);
                map_ref_q    <= map_crc;
                map_ref_ok_q <= !host_wr;
                map_dirty_q  <= 1'b0;
            end else if (host_wr) begin
                map_dirty_q  <= 1'b1;
            end
        end
    end

    // Collect fault events per bit
    always_comb begin
        event_d                 = '0;
        event_d[EFSR_B_REF_DET] = ref_lv_q;
        event_d[EFSR_B_CONV]    = clamp_pos_i || clamp_neg_i;
        event_d[EFSR_B_CONV]    = event_d[EFSR_B_CONV] || cal_range_i || mod_sat_i;
        event_d[EFSR_B_IGNORE]  = ign_fault;
        event_d[EFSR_B_CLK_CNT] = clk_fault;
        event_d[EFSR_B_RD_ADDR] = txn_valid_i && !txn_write_i && !addr_ok(txn_addr_i);
        event_d[EFSR_B_WR_ADDR] = txn_valid_i && txn_write_i && !addr_ok(txn_addr_i);
        event_d[EFSR_B_SER_CRC] = txn_crc_bad_i;
        event_d[EFSR_B_MAP_CRC] = map_bad_q;
        event_d[EFSR_B_ROM_CRC] = rom_bad_q;
    end

    // Host clear mask from a write to the flag register
    always_comb begin
        clear_d = '0;
        if (reg_wr_i && (reg_addr_i == EFSR_ERR_ADDR)) begin
            clear_d = reg_wdata_i[EFSR_NFLAGS-1:0];
        end
    end

    // One sticky flip-flop per flag
    genvar g;
    generate
        for (g = 0; g < EFSR_NFLAGS; g++) begin : g_flag
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    flag_q[g] <= EFSR_ERR_RESET[g];
                end else if (event_d[g] && flag_enable_i[g]) begin
                    flag_q[g] <= 1'b1;
                end else if (clear_d[g]) begin
                    flag_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Registered read data, zero for other offsets
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= EFSR_ERR_RESET;
        end else if (reg_addr_i == EFSR_ERR_ADDR) begin
            rdata_q <= {{(EFSR_REG_W - EFSR_NFLAGS){1'b0}}, flag_q};
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata_o   = rdata_q;
    assign error_flags_o = {{(EFSR_REG_W - EFSR_NFLAGS){1'b0}}, flag_q};
    assign rom_busy_o    = rom_busy;
endmodule : efsr_top

// ==== tb/efsr_monitor.sv ====
// Port checker for the error flag register block
`timescale 1ns/100ps
module efsr_monitor
    import efsr_pkg::*;
(
    input wire logic                   clk_i,
    input wire logic                   arst_n_i,
    input wire logic [7:0]             reg_addr_i,
    input wire logic                   reg_wr_i,
    input wire logic [EFSR_REG_W-1:0]  reg_wdata_i,
    input wire logic [EFSR_REG_W-1:0]  reg_rdata_o,
    input wire logic                   txn_valid_i,
    input wire logic                   txn_write_i,
    input wire logic [7:0]             txn_addr_i,
    input wire logic                   txn_crc_bad_i,
    input wire logic [EFSR_NFLAGS-1:0] flag_enable_i,
    input wire logic                   clamp_pos_i,
    input wire logic                   clamp_neg_i,
    input wire logic                   cal_range_i,
    input wire logic                   mod_sat_i,
    input wire logic                   rom_busy_o,
    input wire logic [EFSR_REG_W-1:0]  error_flags_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Bits that a host write this cycle asks to clear
    wire logic       clr_w = reg_wr_i && (reg_addr_i == EFSR_ERR_ADDR);
    wire logic [8:0] clr_m = clr_w ? reg_wdata_i[8:0] : 9'h0;
    reserved_zero_a: assert property (error_flags_o[15:9] == 7'h0)
        else $error("reserved flag bits not zero");
    read_data_a: assert property (##1 reg_rdata_o == (($past(reg_addr_i) == EFSR_ERR_ADDR) ?
        $past(error_flags_o) : 16'h0)) else $error("read data mismatch");
    enable_gate_a: assert property (##1 (error_flags_o[8:0] & ~$past(error_flags_o[8:0])
        & ~$past(flag_enable_i) & ~flag_enable_i) == 9'h0) else $error("disabled flag rose");
    flags_sticky_a: assert property (##1 ($past(error_flags_o[8:0]) & ~$past(clr_m)
        & ~error_flags_o[8:0]) == 9'h0) else $error("flag dropped without clear");
    clear_bit_a: assert property (clr_w && reg_wdata_i[2] && !txn_crc_bad_i |=> !error_flags_o[2])
        else $error("flag not cleared by write");
    crc_set_a: assert property (txn_crc_bad_i && flag_enable_i[2] |=> error_flags_o[2])
        else $error("serial crc flag not set");
    bad_read_a: assert property (txn_valid_i && !txn_write_i && txn_addr_i > EFSR_LAST_ADDR
        && flag_enable_i[4] |=> error_flags_o[4]) else $error("bad read flag not set");
    bad_write_a: assert property (txn_valid_i && txn_write_i && txn_addr_i > EFSR_LAST_ADDR
        && flag_enable_i[3] |=> error_flags_o[3]) else $error("bad write flag not set");
    conv_set_a: assert property ((clamp_pos_i || clamp_neg_i || cal_range_i || mod_sat_i)
        && flag_enable_i[7] |=> error_flags_o[7]) else $error("converter flag not set");
    // Main scenarios reached
    clear_seen_c: cover property (clr_w && |(error_flags_o[8:0] & reg_wdata_i[8:0]));
    crc_seen_c: cover property (txn_crc_bad_i && clr_w && reg_wdata_i[2]);
    rom_end_c: cover property ($fell(rom_busy_o));
endmodule : efsr_monitor

bind efsr_top efsr_monitor efsr_monitor_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .txn_valid_i(txn_valid_i),
    .txn_write_i(txn_write_i), .txn_addr_i(txn_addr_i), .txn_crc_bad_i(txn_crc_bad_i),
    .flag_enable_i(flag_enable_i), .clamp_pos_i(clamp_pos_i), .clamp_neg_i(clamp_neg_i),
    .cal_range_i(cal_range_i), .mod_sat_i(mod_sat_i), .rom_busy_o(rom_busy_o), .error_flags_o(error_flags_o));

// ==== tb/efsr_far_model.sv ====
// ROM and register map contents seen by the block
`timescale 1ns/100ps
module efsr_far_model (
    input  wire logic [7:0]  rom_addr_i,  // ROM word address
    output logic      [15:0] rom_data_o,  // ROM word, combinational
    input  wire logic [5:0]  map_addr_i,  // Map word address
    output logic      [15:0] map_data_o,  // Map word, combinational
    input  wire logic        corrupt_i    // Upset one map word with no write
);
    // Address-derived words so every location differs
    assign rom_data_o = {rom_addr_i, ~rom_addr_i};
    assign map_data_o = {10'h0, map_addr_i} ^ ((corrupt_i && map_addr_i == 6'h05) ? 16'h0100 : 16'h0);
endmodule : efsr_far_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the error flag register block
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb_top
    import efsr_pkg::*;
;
    logic        clk_i = 1'b0, arst_n_i = 1'b0, reg_wr_i, txn_valid_i, txn_write_i, sclk_i, cs_n_i;
    logic        ref_below_i, corrupt, rom_busy_o;
    logic [4:0]  evt;            // clamp_pos, clamp_neg, cal, sat, serial crc
    logic [7:0]  reg_addr_i, txn_addr_i, rom_addr_o, rom_ref_crc_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, error_flags_o, rom_data_i, map_data_i;
    logic [8:0]  flag_enable_i;
    logic [5:0]  map_addr_o;
    int          bad_count, checks_done, cyc, i, n;
    always #10 clk_i = ~clk_i;
    efsr_top #(.MAP_PERIOD_CYC(200)) efsr_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .txn_valid_i(txn_valid_i),
        .txn_write_i(txn_write_i), .txn_addr_i(txn_addr_i), .txn_crc_bad_i(evt[4]), .sclk_i(sclk_i),
        .cs_n_i(cs_n_i), .flag_enable_i(flag_enable_i), .ref_below_i(ref_below_i), .clamp_pos_i(evt[0]),
        .clamp_neg_i(evt[1]), .cal_range_i(evt[2]), .mod_sat_i(evt[3]), .rom_addr_o(rom_addr_o),
        .rom_data_i(rom_data_i), .rom_ref_crc_i(rom_ref_crc_i), .rom_busy_o(rom_busy_o),
        .map_addr_o(map_addr_o), .map_data_i(map_data_i), .error_flags_o(error_flags_o));
    efsr_far_model efsr_far_model_i (.rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i),
        .map_addr_i(map_addr_o), .map_data_o(map_data_i), .corrupt_i(corrupt));
    // Expected CRC-8 over the model's ROM, MSB first
    function automatic logic [7:0] rom_crc();
        logic [7:0] c = 8'hff;
        logic [15:0] w;
        for (int a = 0; a < 256; a++) begin
            w = {a[7:0], ~a[7:0]};
            for (int b = 15; b >= 0; b--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[b]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : rom_crc
    // Expected flags after one decoded transaction
    function automatic logic [15:0] exp_txn(logic w, logic [7:0] a);
        return (a > 8'h3f) ? (w ? 16'h0008 : 16'h0010) : 16'h0000;
    endfunction : exp_txn
    task automatic step(int k);
        repeat (k) @(negedge clk_i);
    endtask : step
    task automatic clr(logic [15:0] m);
        @(negedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, EFSR_ERR_ADDR, m};
        @(negedge clk_i) reg_wr_i = 1'b0;
    endtask : clr
    task automatic rd(logic [7:0] a, logic [15:0] e);
        @(negedge clk_i) reg_addr_i = a;
        @(negedge clk_i) `CHK(reg_rdata_o, e)
    endtask : rd
    // One chip-select frame with k serial clock rising edges
    task automatic frame(int k);
        @(negedge clk_i) cs_n_i = 1'b0;
        step(4);
        repeat (k) begin sclk_i = 1'b1; step(4); sclk_i = 1'b0; step(4); end
        cs_n_i = 1'b1;
        step(4);
    endtask : frame
    task automatic pulse(logic [4:0] v);
        @(negedge clk_i) evt = v;
        @(negedge clk_i) evt = 5'h0;
        step(1);
    endtask : pulse
    task automatic reset_rom(logic [7:0] crc);
        rom_ref_crc_i = crc;
        arst_n_i = 1'b0;
        step(16);
        arst_n_i = 1'b1;
    endtask : reset_rom
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 9000) begin bad_count++; test_done(); end
    end
    initial begin
        void'($urandom(88331));
        {reg_wr_i, txn_valid_i, txn_write_i, sclk_i, ref_below_i, corrupt, evt} = '0;
        {reg_addr_i, txn_addr_i, reg_wdata_i} = '0;
        cs_n_i = 1'b1;
        flag_enable_i = 9'h1fd;
        reset_rom(rom_crc());
        step(3);
        `CHK(rom_busy_o, 1'b1)
        frame(8);
        for (n = 0; n < 300 && rom_busy_o; n++) step(1);
        step(5);
        `CHK(error_flags_o, 16'h0040)
        rd(EFSR_ERR_ADDR, 16'h0040);
        rd(8'h05, 16'h0000);
        clr(16'hfe00);
        `CHK(error_flags_o, 16'h0040)
        clr(16'hffff);
        `CHK(error_flags_o, 16'h0000)
        for (int j = 0; j < 5; j++) begin
            n = (j == 0) ? 7 : (j == 1) ? 8 : (j == 2) ? 9 : (j == 3) ? 16 : 1;
            frame(n);
            step(8);
            `CHK(error_flags_o[5], (n % 8) != 0)
            clr(16'hffff);
        end
        for (i = 0; i < 30; i++) begin
            @(negedge clk_i) {txn_valid_i, txn_write_i} = {1'b1, 1'($urandom)};
            txn_addr_i = (i == 0) ? 8'h3f : (i == 1) ? 8'h40 : 8'($urandom);
            @(negedge clk_i) txn_valid_i = 1'b0;
            step(1);
            `CHK(error_flags_o, exp_txn(txn_write_i, txn_addr_i))
            clr(16'h0018);
        end
        for (i = 0; i < 10; i++) begin
            n = (i < 8) ? 7 : 2;
            flag_enable_i[n] = i[0];
            pulse(5'h1 << (i / 2));
            `CHK(error_flags_o[n], i[0])
            clr(16'hffff);
            flag_enable_i = 9'h1fd;
        end
        pulse(5'h11);
        @(negedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i, evt} = {1'b1, EFSR_ERR_ADDR, 16'h0084, 5'h10};
        @(negedge clk_i) {reg_wr_i, evt} = '0;
        `CHK(error_flags_o, 16'h0004)
        ref_below_i = 1'b1;
        step(10);
        ref_below_i = 1'b0;
        step(6);
        `CHK(error_flags_o, 16'h0104)
        clr(16'hffff);
        flag_enable_i[1] = 1'b1;
        step(500);
        `CHK(error_flags_o, 16'h0000)
        corrupt = 1'b1;
        step(500);
        `CHK(error_flags_o[1], 1'b1)
        flag_enable_i = 9'h1fd;
        reset_rom(~rom_crc());
        `CHK(error_flags_o, 16'h0000)
        step(3);
        for (n = 0; n < 300 && rom_busy_o; n++) step(1);
        step(5);
        `CHK(error_flags_o, 16'h0001)
        test_done();
    end
endmodule : tb_top
